// ===== rtl/core_instruction_execute.v
// execute stage for add, and, bit clear/set and bit test-skip operations
`timescale 1ns/1ps
`include "core_exec_defines.vh"

// Overview of operation
// - port read-modify-write uses pin levels
// - timer0 write clears prescaler when assigned
// - pointer change or skip adds idle cycle
// - add_literal_to_w adds literal, updates flags
// - add_w_to_file adds register, updates three flags
// - target_pick 0 to W, 1 to register
// - and_w_with_file ands, zero flag only
// - and_literal_with_w ands, zero flag only
// - bit_clear_file clears lane bit, no flags
// - bit_set_file sets lane bit, no flags
// - bit_test_skip_if_set skips next when set
// - bit ops decoded from 01 class field
module core_instruction_execute (
   input  wire        clk,
   input  wire        srst,
   input  wire [13:0] instrWord,
   input  wire        instrValid,
   output wire        instrReady,
   output wire        discardNext,
   output wire        idleCycle,
   output reg  [6:0]  fileAddr_r,
   input  wire [7:0]  fileRdData,
   output reg         fileWrEn_r,
   output reg  [7:0]  fileWrData_r,
   input  wire [39:0] portPins,
   input  wire        prescalerOnTimer0,
   output reg         prescalerClr_r,
   output reg  [7:0]  wReg_r,
   output reg         carryFlag_r,
   output reg         nibbleCarryFlag_r,
   output reg         zeroFlag_r,
   output reg         illegalOp_r
);

   // ----------------------------------------
   // state machine codes
   // ----------------------------------------
   localparam [2:0] S_FETCH = 3'h1;
   localparam [2:0] S_EXEC  = 3'h2;
   localparam [2:0] S_IDLE  = 3'h4;

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [13:0] instr_r;
   reg  [39:0] pinMeta_r;
   reg  [39:0] pinSync_r;

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   // pins are asynchronous to clk; second stage is the only reader of the first
   always @(posedge clk) begin
      if (srst) begin
         pinMeta_r <= 40'h0;
         pinSync_r <= 40'h0;
      end else begin
         pinMeta_r <= portPins;
         pinSync_r <= pinMeta_r;
      end
   end

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire [1:0] cls      = instr_r[`CLASS_HI:`CLASS_LO];
   wire [3:0] opc      = instr_r[`OPC_HI:`OPC_LO];
   wire [1:0] bitSel   = instr_r[`BITSEL_HI:`BITSEL_LO];
   wire [2:0] lane     = instr_r[`LANE_HI:`LANE_LO];
   wire       target   = instr_r[`TARGET_BIT];
   wire [7:0] literal  = instr_r[`LIT_HI:`LIT_LO];

   wire isAddFile  = (cls == `CLASS_BYTE) && (opc == `OPC_ADD_FILE);
   wire isAndFile  = (cls == `CLASS_BYTE) && (opc == `OPC_AND_FILE);
   wire isAddLit   = (cls == `CLASS_LIT) && (opc[3:1] == `OPC_ADD_LIT_HI);
   wire isAndLit   = (cls == `CLASS_LIT) && (opc == `OPC_AND_LIT);
   wire isBitClr   = (cls == `CLASS_BIT) && (bitSel == `BITSEL_CLEAR);
   wire isBitSet   = (cls == `CLASS_BIT) && (bitSel == `BITSEL_SET);
   wire isBitTest  = (cls == `CLASS_BIT) && (bitSel == `BITSEL_TEST);
   wire isLiteral  = isAddLit | isAndLit;
   wire isKnown    = isAddFile | isAndFile | isLiteral | isBitClr | isBitSet | isBitTest;

   // ----------------------------------------
   // operand selection
   // ----------------------------------------
   wire       isPort   = (fileAddr_r >= `ADDR_PORT_FIRST) && (fileAddr_r <= `ADDR_PORT_LAST);
   wire [6:0] portIdx  = fileAddr_r - `ADDR_PORT_FIRST;
   reg  [7:0] pinByte;
   integer    p;

   always @* begin
      pinByte = `RST_BYTE;
      for (p = 0; p < `PORT_COUNT; p = p + 1) begin
         if (portIdx == p[6:0]) begin
            pinByte = pinSync_r[p*8 +: 8];
         end
      end
   end

   // ports are read back from the pins, not from their output latches
   wire [7:0] fileOperand = isPort ? pinByte : fileRdData;
   wire [7:0] operand     = isLiteral ? literal : fileOperand;

   reg [2:0] aluOp;
   always @* begin
      if (isAddFile || isAddLit) begin
         aluOp = `ALU_ADD;
      end else if (isAndFile || isAndLit) begin
         aluOp = `ALU_AND;
      end else if (isBitClr) begin
         aluOp = `ALU_CLR;
      end else if (isBitSet) begin
         aluOp = `ALU_SET;
      end else begin
         aluOp = `ALU_PASS;
      end
   end

   wire [7:0] aluResult;
   wire       aluCarry;
   wire       aluNibble;
   wire       aluZero;
   wire       aluLaneBit;

   exec_alu u_alu (
      .aluOp     (aluOp),
      .wIn       (wReg_r),
      .opIn      (operand),
      .lane      (lane),
      .result    (aluResult),
      .carryOut  (aluCarry),
      .nibbleOut (aluNibble),
      .zeroOut   (aluZero),
      .laneBit   (aluLaneBit)
   );

   // ----------------------------------------
   // result routing
   // ----------------------------------------
   wire execNow   = (state_r == S_EXEC);
   wire toW       = isLiteral || ((isAddFile || isAndFile) && (target == `TARGET_W));
   wire toFile    = isBitClr || isBitSet || ((isAddFile || isAndFile) && (target != `TARGET_W));
   wire skipTaken = isBitTest && aluLaneBit;
   // a write to the low pointer byte moves the program pointer
   wire ptrWrite  = toFile && (fileAddr_r == `ADDR_PTR_LOW);
   wire needIdle  = skipTaken || ptrWrite;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always @* begin
      case (state_r)
         S_FETCH: state_nxt = instrValid ? S_EXEC : S_FETCH;
         S_EXEC:  state_nxt = needIdle ? S_IDLE : S_FETCH;
         S_IDLE:  state_nxt = S_FETCH;
         default: state_nxt = S_FETCH;
      endcase
   end

   // ready stays low through execute and idle, so only one word is in flight
   assign instrReady  = (state_r == S_FETCH);
   assign idleCycle   = (state_r == S_IDLE);
   assign discardNext = (state_r == S_IDLE);

   always @(posedge clk) begin
      if (srst) begin
         state_r    <= S_FETCH;
         instr_r    <= 14'h0;
         fileAddr_r <= `RST_ADDR;
      end else begin
         state_r <= state_nxt;
         if (instrReady && instrValid) begin
            instr_r    <= instrWord;
            fileAddr_r <= instrWord[`ADDR_HI:`ADDR_LO];
         end
      end
   end

   // ----------------------------------------
   // writeback and flags
   // ----------------------------------------
   // write lands one cycle after execute; a synchronous file makes it visible to the next execute
   always @(posedge clk) begin
      if (srst) begin
         wReg_r            <= `RST_BYTE;
         carryFlag_r       <= 1'b0;
         nibbleCarryFlag_r <= 1'b0;
         zeroFlag_r        <= 1'b0;
         fileWrEn_r        <= 1'b0;
         fileWrData_r      <= `RST_BYTE;
         prescalerClr_r    <= 1'b0;
         illegalOp_r       <= 1'b0;
      end else begin
         fileWrEn_r     <= execNow && isKnown && toFile;
         // bit clear/set always write back, so on the timer count they clear it too when it is assigned to timer0
         prescalerClr_r <= execNow && isKnown && toFile && (fileAddr_r == `ADDR_TIMER0)
                           && prescalerOnTimer0;
         // unsupported words only raise the pulse; no register or flag moves
         illegalOp_r    <= execNow && !isKnown;
         if (execNow && toFile) begin
            fileWrData_r <= aluResult;
         end
         if (execNow && toW) begin
            wReg_r <= aluResult;
         end
         if (execNow && (isAddFile || isAddLit)) begin
            carryFlag_r       <= aluCarry;
            nibbleCarryFlag_r <= aluNibble;
         end
         if (execNow && (isAddFile || isAddLit || isAndFile || isAndLit)) begin
            zeroFlag_r <= aluZero;
         end
      end
   end

endmodule // core_instruction_execute

// ===== rtl/core_exec_defines.vh
// constants for the instruction execute block
`ifndef CORE_EXEC_DEFINES_VH
`define CORE_EXEC_DEFINES_VH

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define CLASS_HI        13
`define CLASS_LO        12
`define OPC_HI          11
`define OPC_LO          8
`define BITSEL_HI       11
`define BITSEL_LO       10
`define LANE_HI         9
`define LANE_LO         7
`define TARGET_BIT      7
`define ADDR_HI         6
`define ADDR_LO         0
`define LIT_HI          7
`define LIT_LO          0

// ----------------------------------------
// encodings
// ----------------------------------------
`define CLASS_BYTE      2'h0
`define CLASS_BIT       2'h1
`define CLASS_LIT       2'h3
`define OPC_ADD_FILE    4'h7
`define OPC_AND_FILE    4'h5
`define OPC_AND_LIT     4'h9
`define OPC_ADD_LIT_HI  3'h7
`define BITSEL_CLEAR    2'h0
`define BITSEL_SET      2'h1
`define BITSEL_TEST     2'h3
`define TARGET_W        1'h0

// ----------------------------------------
// alu operation codes
// ----------------------------------------
`define ALU_ADD         3'h0
`define ALU_AND         3'h1
`define ALU_CLR         3'h2
`define ALU_SET         3'h3
`define ALU_PASS        3'h4

// ----------------------------------------
// register file addresses
// ----------------------------------------
`define ADDR_TIMER0     7'h01
`define ADDR_PTR_LOW    7'h02
`define ADDR_PORT_FIRST 7'h05
`define ADDR_PORT_LAST  7'h09
`define PORT_COUNT      5

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_BYTE        8'h00
`define RST_ADDR        7'h00

`endif

// ===== rtl/exec_alu.v
// combinational arithmetic and bit unit of the execute block
`timescale 1ns/1ps
`include "core_exec_defines.vh"

module exec_alu (
   input  wire [2:0] aluOp,
   input  wire [7:0] wIn,
   input  wire [7:0] opIn,
   input  wire [2:0] lane,
   output reg  [7:0] result,
   output reg        carryOut,
   output reg        nibbleOut,
   output wire       zeroOut,
   output wire       laneBit
);

   reg [8:0] sum;
   reg [4:0] lowSum;
   reg [7:0] laneMask;

   assign zeroOut = (result == `RST_BYTE);
   assign laneBit = opIn[lane];

   always @* begin
      sum      = {1'b0, wIn} + {1'b0, opIn};
      lowSum   = {1'b0, wIn[3:0]} + {1'b0, opIn[3:0]};
      laneMask = 8'h01 << lane;
      carryOut  = sum[8];
      nibbleOut = lowSum[4];
      case (aluOp)
         `ALU_ADD: result = sum[7:0];
         `ALU_AND: result = wIn & opIn;
         `ALU_CLR: result = opIn & ~laneMask;
         `ALU_SET: result = opIn | laneMask;
         default:  result = opIn;
      endcase
   end

endmodule // exec_alu

// ===== sim/core_exec_assertions.sv
// assertions on the execute block ports
`timescale 1ns/1ps
module core_exec_assertions (
   input wire        clk,
   input wire        srst,
   input wire [13:0] instrWord,
   input wire        instrValid,
   input wire        instrReady,
   input wire        discardNext,
   input wire        idleCycle,
   input wire [6:0]  fileAddr_r,
   input wire        fileWrEn_r,
   input wire        prescalerOnTimer0,
   input wire        prescalerClr_r,
   input wire [7:0]  wReg_r,
   input wire        carryFlag_r,
   input wire        nibbleCarryFlag_r,
   input wire        zeroFlag_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire acc = instrValid && instrReady;
   wire fileOp = instrWord[13:8] == 6'h07 || instrWord[13:8] == 6'h05;
   // results land one cycle after the execute cycle
   sequence s_exec(c);
      acc && c ##1 1'b1;
   endsequence
   a_busy_refuse: assert property (acc |=> !instrReady)
      else $error("ready while executing");
   a_idle_shape: assert property (idleCycle |-> discardNext && !instrReady ##1 instrReady)
      else $error("idle cycle malformed");
   a_clr_match: assert property (fileWrEn_r && fileAddr_r == 7'h01 |->
      prescalerClr_r == $past(prescalerOnTimer0)) else $error("prescaler clear wrong");
   a_add_sum: assert property (s_exec(instrWord[13:9] == 5'h1f) |=>
      wReg_r == $past(wReg_r, 2) + $past(instrWord[7:0], 2) && zeroFlag_r == (wReg_r == 8'h00))
      else $error("literal add wrong");
   a_and_keep: assert property (s_exec(instrWord[13:8] == 6'h39 || instrWord[13:8] == 6'h05) |=>
      $stable({carryFlag_r, nibbleCarryFlag_r})) else $error("and touched carries");
   a_bit_keep: assert property (s_exec(instrWord[13:12] == 2'h1) |=>
      $stable({carryFlag_r, nibbleCarryFlag_r, zeroFlag_r})) else $error("bit op touched flags");
   a_to_w: assert property (s_exec(fileOp && !instrWord[7]) |=> !fileWrEn_r)
      else $error("write with target w");
   a_to_file: assert property (s_exec(fileOp && instrWord[7]) |=>
      fileWrEn_r && fileAddr_r == $past(instrWord[6:0], 2)) else $error("missing write back");
endmodule // core_exec_assertions

// ===== sim/regfile_model.sv
// data register file seen by the execute block
`timescale 1ns/1ps
module regfile_model (
   input  wire       clk,
   input  wire [6:0] fileAddr_r,
   input  wire       fileWrEn_r,
   input  wire [7:0] fileWrData_r,
   output wire [7:0] fileRdData
);
   // port addresses hold latch contents, deliberately unlike the pins
   reg [7:0] mem [0:127];
   assign fileRdData = mem[fileAddr_r];
   always @(posedge clk) begin
      if (fileWrEn_r) mem[fileAddr_r] <= fileWrData_r;
   end
endmodule // regfile_model

// ===== sim/tb_core_instruction_execute.sv
// self-checking bench for the execute block
`timescale 1ns/1ps
module tb_core_instruction_execute;
   reg          clk = 1'b0;
   reg          srst = 1'b1;
   reg          instrValid = 1'b0;
   reg          prescalerOnTimer0 = 1'b0;
   reg  [13:0]  instrWord = 14'h0000;
   reg  [39:0]  portPins = 40'h0;
   wire         instrReady, discardNext, idleCycle, fileWrEn_r, prescalerClr_r;
   wire         carryFlag_r, nibbleCarryFlag_r, zeroFlag_r, illegalOp_r;
   wire [6:0]   fileAddr_r;
   wire [7:0]   fileRdData, fileWrData_r, wReg_r;
   logic [14:0] notes [$];
   integer      mismatches = 0, checks = 0, cyc, i, idles;
   reg  [1:0]   pulses = 2'h0;
   reg  [7:0]   w = 8'h00, v, k, m;
   reg  [6:0]   a;
   reg          c = 1'b0, h = 1'b0, z = 1'b0;
   core_instruction_execute dut (.*);
   regfile_model rf (.*);
   always #4 clk = ~clk;
   task check(input [15:0] seen, input [15:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // write back lands one edge after the result shows; the spare cycle at the end keeps the next preload safe
   task run(input [13:0] word, input integer len);
      instrWord = word;
      instrValid = 1'b1;
      @(negedge clk);
      instrValid = 1'b0;
      cyc = 0;
      idles = 0;
      while (instrReady !== 1'b1 && cyc < 8) begin
         cyc = cyc + 1;
         @(negedge clk);
         // one-cycle pulses stand only in the first cycle after execute
         if (cyc == 1) pulses = {prescalerClr_r, illegalOp_r};
         if (idleCycle === 1'b1 && discardNext === 1'b1) idles = idles + 1;
      end
      check(cyc[15:0], len[15:0]);
      check(idles[15:0], len[15:0] - 16'h0001);
      @(negedge clk);
   endtask
   task add(input [7:0] x);
      {c, v} = w + x;
      h = 5'h00 + w[3:0] + x[3:0] > 5'h0f;
      z = v == 8'h00;
   endtask
   task flags;
      check({5'h00, carryFlag_r, nibbleCarryFlag_r, zeroFlag_r, wReg_r}, {5'h00, c, h, z, w});
   endtask
   // ---------------
   // write-back watch
   // ---------------
   always @(negedge clk) begin
      if (fileWrEn_r === 1'b1) check({fileAddr_r, fileWrData_r}, notes.size() > 0 ? notes.pop_front() : 15'h7fff);
   end
   initial begin
      #100000;
      mismatches = mismatches + 1;
      final_report;
   end
   initial begin
      i = $urandom(32'h0a7aeb02);
      repeat (20) @(negedge clk);
      srst = 1'b0;
      for (i = 0; i < 24; i = i + 1) begin
         k = $urandom;
         if (i % 4 == 0) k = 8'h00 - w;
         if (i % 4 == 1) k = ~w;
         if (i % 2 == 0) begin
            add(k);
            w = v;
            run({5'h1f, i[1], k}, 1);
         end else begin
            w = w & k;
            z = w == 8'h00;
            run({6'h39, k}, 1);
         end
         flags;
      end
      $display("literal operations done");
      for (i = 0; i < 16; i = i + 1) begin
         a = 7'h20 + $urandom % 96;
         m = $urandom;
         rf.mem[a] = m;
         if (i[1]) add(m);
         else begin
            v = w & m;
            z = v == 8'h00;
         end
         if (i[0]) notes.push_back({a, v});
         else w = v;
         run({2'h0, i[1] ? 4'h7 : 4'h5, i[0], a}, 1);
         flags;
      end
      $display("file operations done");
      for (i = 0; i < 16; i = i + 1) begin
         a = 7'h20 + $urandom % 96;
         m = $urandom;
         rf.mem[a] = m;
         notes.push_back({a, i[3] ? m | 8'h01 << i[2:0] : m & ~(8'h01 << i[2:0])});
         run({3'h2, i[3], i[2:0], a}, 1);
         flags;
      end
      portPins[39:8] = $urandom;
      portPins[7:0] = $urandom;
      // the pins need two edges through the synchroniser before any execute cycle
      repeat (2) @(negedge clk);
      for (i = 0; i < 5; i = i + 1) begin
         m = portPins[8 * i +: 8];
         rf.mem[7'h05 + i] = ~m;
         notes.push_back({7'h05 + i[6:0], m | 8'h80});
         run({4'h5, 3'h7, 7'h05 + i[6:0]}, 1);
      end
      for (i = 0; i < 8; i = i + 1) begin
         m = $urandom;
         rf.mem[7'h30] = m;
         run({4'h7, i[2:0], 7'h30}, m[i[2:0]] ? 2 : 1);
         flags;
      end
      $display("bit operations done");
      for (i = 0; i < 3; i = i + 1) begin
         prescalerOnTimer0 = i[0];
         a = i[1] ? 7'h02 : 7'h01;
         m = $urandom;
         rf.mem[a] = m;
         add(m);
         notes.push_back({a, v});
         run({6'h07, 1'b1, a}, i[1] ? 2 : 1);
         check(pulses[1], !i[1] && i[0]);
         check(pulses[0], 1'b0);
         flags;
      end
      run(14'h1820, 1);
      check(pulses[0], 1'b1);
      flags;
      check(notes.size(), 0);
      $display("timer, pointer and illegal done");
      final_report;
   end
endmodule // tb_core_instruction_execute
bind core_instruction_execute core_exec_assertions chk (.*);
